/* File: hw/dilcf_pkg.sv */
// Package for the converter input latch and code formatter
package dilcf_pkg;
  localparam int DILCF_WIDTH = 12;
  localparam logic [11:0] DILCF_FULL_CODE = 12'hFFF;
  localparam logic [11:0] DILCF_RST_CODE = 12'h000;
  localparam logic [2:0] DILCF_SYNC_RST = 3'h0;
  localparam int DILCF_LATENCY = 1;
  // Input coding selected by the static format pin
  typedef enum logic {DILCF_FMT_BINARY, DILCF_FMT_TWOS} dilcf_fmt_t;
  // Differential drive pair for the current switch array
  typedef struct packed {
    logic [11:0] positive_current_output;
    logic [11:0] complementary_current_output;
    logic output_enable;
  } dilcf_drive_t;
endpackage

/* File: hw/dilcf_sync3.sv */
// Three-stage synchroniser with agreement filter for a slow pin
`timescale 1ns/100ps
`default_nettype none
module dilcf_sync3 (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic level_out
);
  import dilcf_pkg::*;
  logic [2:0] stage_ff;
  logic [2:0] nxt_stage;
  logic level_ff;
  logic nxt_level;

  // Shift chain; stage 0 is read only by stage 1
  always_comb
  begin
    nxt_stage = {stage_ff[1:0], pin_in};
    nxt_level = level_ff;
    if (stage_ff[1] == stage_ff[2])
    begin
      nxt_level = stage_ff[2];
    end
    if (rst)
    begin
      nxt_stage = DILCF_SYNC_RST;
      nxt_level = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    stage_ff <= nxt_stage;
    level_ff <= nxt_level;
  end

  assign level_out = level_ff;
endmodule
`default_nettype wire

/* File: hw/dilcf_top.sv */
// Sample latch, code formatting and current steering code for the converter
// Functional notes
// - Capture whole word each rising clock edge
// - Output follows capture by one cycle
// - Format pin static: low binary, high twos
// - Twos complement: invert only the MSB
// - Positive output proportional to code
// - Complementary output gets 4095 minus code
// - Power-down high disables output current
`timescale 1ns/100ps
`default_nettype none
module dilcf_top #(
  parameter int WIDTH = dilcf_pkg::DILCF_WIDTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] sample_word_lines,
  input wire logic format_select,
  input wire logic power_down,
  output var dilcf_pkg::dilcf_drive_t drive
);
  import dilcf_pkg::*;

  logic [WIDTH-1:0] word_ff;
  logic [WIDTH-1:0] nxt_word;
  dilcf_drive_t drive_ff;
  dilcf_drive_t nxt_drive;
  logic [1:0] pin_raw;
  logic [1:0] pin_sync;
  logic fmt_sync;
  logic sleep_sync;
  dilcf_fmt_t fmt;

  // Slow pins gathered for one filtered chain each; bit 0 format, bit 1 power down
  assign pin_raw = {power_down, format_select};

  // Format pin is static, but still comes from off-chip; an unconnected
  // power-down pin is modelled by the pad pulldown, so low means awake
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_pin
      dilcf_sync3 dilcf_sync3_inst (
        .clk(clk),
        .rst(rst),
        .pin_in(pin_raw[g]),
        .level_out(pin_sync[g])
      );
    end
  endgenerate

  // Named views of the filtered pins
  assign fmt_sync = pin_sync[0];
  assign sleep_sync = pin_sync[1];

  assign fmt = fmt_sync ? DILCF_FMT_TWOS : DILCF_FMT_BINARY;

  // Maps a captured word to the conversion code
  function automatic logic [WIDTH-1:0] to_code(input logic [WIDTH-1:0] w, input dilcf_fmt_t f);
    logic [WIDTH-1:0] c;
    c = w;
    if (f == DILCF_FMT_TWOS)
    begin
      c[WIDTH-1] = ~w[WIDTH-1];
    end
    return c;
  endfunction

  // Data lines sampled only at the edge; no bypass path exists
  always_comb
  begin
    nxt_word = sample_word_lines;
    if (rst)
    begin
      nxt_word = '0;
    end
  end

  // Drive codes; complement of code equals all ones minus code
  // Asleep only drops the enable: codes keep moving, so waking needs no
  // refill of the pipeline and the first awake sample is already current
  always_comb
  begin
    nxt_drive.positive_current_output = to_code(word_ff, fmt);
    nxt_drive.complementary_current_output = ~to_code(word_ff, fmt);
    nxt_drive.output_enable = ~sleep_sync;
    if (rst)
    begin
      nxt_drive.positive_current_output = DILCF_RST_CODE;
      nxt_drive.complementary_current_output = DILCF_FULL_CODE;
      nxt_drive.output_enable = 1'b0;
    end
  end

  // Capture and output stages; output changes once per edge only
  always_ff @(posedge clk)
  begin
    word_ff <= nxt_word;
    drive_ff <= nxt_drive;
  end

  assign drive = drive_ff;

  // Checks on the datapath. Those against pin history skip edges whose history includes a reset
  // cycle, since the registers then hold reset codes instead of pin history.
  // For those, expected values come from the pins, never from the formatter itself.

  // Register holds exactly what the lines showed at the previous edge
  a_capture_word: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> word_ff == $past(sample_word_lines))
    else $error("captured word differs from sampled lines");

  // Straight binary: the code leaves two edges after the word was on the lines
  a_latency_binary: assert property (@(posedge clk) disable iff (rst)
    (!$past(rst) && !$past(rst, 2) && $past(fmt) == DILCF_FMT_BINARY) |->
      drive.positive_current_output == $past(sample_word_lines, 2))
    else $error("binary output latency wrong");

  // Twos format: same latency, top bit flipped
  a_twos_msb: assert property (@(posedge clk) disable iff (rst)
    (!$past(rst) && !$past(rst, 2) && $past(fmt) == DILCF_FMT_TWOS) |->
      drive.positive_current_output ==
        {~$past(sample_word_lines[WIDTH-1], 2), $past(sample_word_lines[WIDTH-2:0], 2)})
    else $error("twos complement mapping wrong");

  // Lower bits pass through untouched in either format
  generate
    for (genvar b = 0; b < WIDTH - 1; b++)
    begin : g_low_bits
      a_low_bit_pass: assert property (@(posedge clk) disable iff (rst)
        (!$past(rst) && !$past(rst, 2)) |->
          drive.positive_current_output[b] == $past(sample_word_lines[b], 2))
        else $error("lower code bit altered by format");
    end
  endgenerate

  // Complementary code against pin history, not against the inverter
  a_comp_binary: assert property (@(posedge clk) disable iff (rst)
    (!$past(rst) && !$past(rst, 2) && $past(fmt) == DILCF_FMT_BINARY) |->
      drive.complementary_current_output == DILCF_FULL_CODE - $past(sample_word_lines, 2))
    else $error("complementary code wrong in binary format");

  // In twos format the complement sees the flipped top bit as well
  a_comp_twos: assert property (@(posedge clk) disable iff (rst)
    (!$past(rst) && !$past(rst, 2) && $past(fmt) == DILCF_FMT_TWOS) |->
      drive.complementary_current_output ==
        DILCF_FULL_CODE - {~$past(sample_word_lines[WIDTH-1], 2), $past(sample_word_lines[WIDTH-2:0], 2)})
    else $error("complementary code wrong in twos format");

  // Sum of the two codes is always the all-ones code
  a_complement_sum: assert property (@(posedge clk) disable iff (rst)
    (drive.positive_current_output + drive.complementary_current_output) == DILCF_FULL_CODE)
    else $error("outputs not complementary");

  // Zero code steers everything to the complementary side
  a_zero_code: assert property (@(posedge clk) disable iff (rst)
    (!$past(rst) && $past(word_ff) == '0 && $past(fmt) == DILCF_FMT_BINARY) |->
      drive.complementary_current_output == DILCF_FULL_CODE)
    else $error("zero code not full scale on complementary output");

  // All-ones word in binary format gives the full code on the positive side
  a_code_track: assert property (@(posedge clk) disable iff (rst)
    (!$past(rst) && $past(word_ff) == DILCF_FULL_CODE[WIDTH-1:0] && $past(fmt) == DILCF_FMT_BINARY) |->
      drive.positive_current_output == DILCF_FULL_CODE[WIDTH-1:0])
    else $error("full code not on positive output");

  // Format decode follows a high filtered pin
  a_fmt_select: assert property (@(posedge clk) disable iff (rst)
    fmt_sync |-> fmt == DILCF_FMT_TWOS)
    else $error("format select decoded wrongly");

  // Format decode follows a low filtered pin
  a_fmt_clear: assert property (@(posedge clk) disable iff (rst)
    !fmt_sync |-> fmt == DILCF_FMT_BINARY)
    else $error("binary format decoded wrongly");

  // Output current switched off the edge after the pin reads high
  a_sleep_off: assert property (@(posedge clk) disable iff (rst)
    $rose(sleep_sync) |=> !drive.output_enable)
    else $error("power down did not disable output");

  // Stays off for as long as the pin reads high
  a_sleep_hold: assert property (@(posedge clk) disable iff (rst)
    sleep_sync |=> !drive.output_enable)
    else $error("output current on while powered down");

  // Current back on the edge after the pin reads low again
  a_wake_on: assert property (@(posedge clk) disable iff (rst)
    $fell(sleep_sync) |=> drive.output_enable)
    else $error("output current not restored after power down");

  // Enable is the inverse of the filtered pin one edge late, except on the edge after a reset cycle
  a_enable_track: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> drive.output_enable == !$past(sleep_sync))
    else $error("output enable does not follow power down pin");

  // Reset parks the outputs at zero code with the current off
  a_reset_drive: assert property (@(posedge clk)
    rst |=> (drive.positive_current_output == DILCF_RST_CODE &&
      drive.complementary_current_output == DILCF_FULL_CODE && !drive.output_enable))
    else $error("reset did not park the outputs");

  // Stable word and format keep the code still
  a_hold_stable: assert property (@(posedge clk) disable iff (rst)
    (!$past(rst) && $stable(word_ff) && $stable(fmt)) |=> $stable(drive.positive_current_output))
    else $error("output moved without new code");

  // A code change needs a new word, a new format or a reset behind it
  a_change_cause: assert property (@(posedge clk) disable iff (rst)
    $changed(drive.positive_current_output) |->
      ($past(word_ff) != $past(word_ff, 2)) || ($past(fmt) != $past(fmt, 2)) ||
      $past(rst) || $past(rst, 2))
    else $error("code changed without a new word");

  // Main scenarios worth seeing at least once
  c_twos_mode: cover property (@(posedge clk) disable iff (rst) fmt == DILCF_FMT_TWOS);
  c_full_scale: cover property (@(posedge clk) disable iff (rst)
    drive.positive_current_output == DILCF_FULL_CODE[WIDTH-1:0]);
  c_zero_code: cover property (@(posedge clk) disable iff (rst)
    drive.complementary_current_output == DILCF_FULL_CODE && drive.output_enable);
  c_sleep: cover property (@(posedge clk) disable iff (rst) $fell(drive.output_enable));
  c_wake: cover property (@(posedge clk) disable iff (rst) $rose(drive.output_enable));
endmodule
`default_nettype wire

/* File: sim/dilcf_src.sv */
// Source model driving sample words into the converter
`timescale 1ns/100ps
`default_nettype none
module dilcf_src (
  input wire logic clk,
  input wire logic [11:0] word_req,
  output logic [11:0] sample_word_lines
);
  initial sample_word_lines = 12'h000;
  // Launch on falling edge, far from capture; bench clock keeps rate
  always @(negedge clk)
    sample_word_lines <= word_req;
endmodule
`default_nettype wire

/* File: sim/dilcf_top_tb_top.sv */
// Self-checking bench for the converter latch and formatter
`timescale 1ns/100ps
`default_nettype none
module dilcf_top_tb_top;
  import dilcf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fmt = 1'b0;
  logic pd = 1'b0;
  logic [11:0] req = 12'h000;
  logic [11:0] lines;
  dilcf_drive_t drive;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [11:0] w [6] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'h5A3, 12'h000};
  dilcf_src dilcf_src_inst (.clk(clk), .word_req(req), .sample_word_lines(lines));
  dilcf_top dilcf_top_inst (.clk(clk), .rst(rst), .sample_word_lines(lines), .format_select(fmt),
    .power_down(pd), .drive(drive));
  // 20 MHz clock
  initial forever #25 clk = ~clk;
  // Hang guard, well above the fewer than eighty cycles needed
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  task check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Back-to-back words; output looked at two falling edges after launch
  task t_stream(input logic f);
    logic [11:0] c;
    @(negedge clk) fmt = f;
    repeat (6) @(negedge clk);
    // Two extra cycles drain the last words of the list
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      if (i < 6)
        req <= w[i];
      @(negedge clk);
      if (i >= 2)
      begin
        c = f ? w[i-2] ^ 12'h800 : w[i-2];
        check("pos", drive.positive_current_output, c);
        check("comp", drive.complementary_current_output, 12'hFFF - c);
      end
    end
  endtask
  // Sleep pin passes a slow synchroniser, so allow six cycles
  task t_sleep;
    @(negedge clk) pd = 1'b1;
    repeat (6) @(negedge clk);
    check("oe", {11'h000, drive.output_enable}, 12'h000);
    pd = 1'b0;
    repeat (6) @(negedge clk);
    check("oe", {11'h000, drive.output_enable}, 12'h001);
  endtask
  // Mid-run reset: outputs park, then the stream must resume cleanly
  task t_reset;
    @(negedge clk) rst = 1'b1;
    repeat (3) @(negedge clk);
    check("pos", drive.positive_current_output, 12'h000);
    check("comp", drive.complementary_current_output, 12'hFFF);
    check("oe", {11'h000, drive.output_enable}, 12'h000);
    rst = 1'b0;
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    check("pos", drive.positive_current_output, 12'h000);
    check("comp", drive.complementary_current_output, 12'hFFF);
    check("oe", {11'h000, drive.output_enable}, 12'h000);
    rst = 1'b0;
    t_stream(1'b0);
    t_stream(1'b1);
    t_reset();
    t_stream(1'b1);
    t_sleep();
    end_sim();
  end
endmodule
`default_nettype wire
